// >>> logic/fpc_defines.svh
// Constants for the flash protection controller: offsets, fields, resets, timing.
// Assumes inclusion by the package, the design file and the bench.
// Operation
// - Erase one selectable 1 KB block to ones
// - Program one word, bits only one-to-zero
// - Protect 2 KB regions, read and program bit
// - Time flash from reload equal MHz minus one
// - Program-enable zero refuses program and erase
// - Read-enable zero allows only instruction fetches
// - Enable combinations give documented access types
// - Protected data read answers with bus fault
// - Refused change raises access flag, mask gates
// - Factory protection bits all read one
// - Bits clear only; uncommitted restored at power-on
// - Commit command stores protection values nonvolatilely
// - Data-bus literal loads from execute-only blocked
// - Both debug bits cleared block debug port
// - Disabled debug can never be re-enabled
// - Completion flag set when program/erase ends
// - Raw status always visible; masked follows mask
// - Write one to clear register clears flag
// - Keyed command starts operation; bit self-clears
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ---------------------------------------------------------------
`define FPC_OFF_ADDR   12'h000
`define FPC_OFF_DATA   12'h004
`define FPC_OFF_CMD    12'h008
`define FPC_OFF_RIS    12'h00C
`define FPC_OFF_IM     12'h010
`define FPC_OFF_MISC   12'h014
`define FPC_OFF_RE     12'h018
`define FPC_OFF_PE     12'h01C
`define FPC_OFF_USEC   12'h020
`define FPC_OFF_DBG    12'h024

// ---------------------------------------------------------------
// Fields and keys
// ---------------------------------------------------------------
`define FPC_CMD_KEY    16'hA442
`define FPC_CMD_WRITE  4'h1
`define FPC_CMD_ERASE  4'h2
`define FPC_CMD_COMMIT 4'h8
`define FPC_ST_PROG    0
`define FPC_ST_ACC     1
`define FPC_CMT_RE     32'h0000_0000
`define FPC_CMT_PE     32'h0000_0001
`define FPC_CMT_DBG    32'h7510_0000

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define FPC_USEC_RST   8'h18
`define FPC_PROT_RST   32'hFFFF_FFFF
`define FPC_DBG_RST    32'hFFFF_FFFE
`define FPC_PGM_US     20
`define FPC_ERASE_US   20

`endif

// >>> logic/fpc_pkg.sv
// Types shared by the flash protection controller and its bench.
// Assumes fpc_defines.svh is on the include path.
`default_nettype none
`include "fpc_defines.svh"

package fpc_pkg;

  // Kind of a flash read access
  typedef enum logic [1:0] {
    FPC_FETCH = 2'h0,   // Instruction bus fetch
    FPC_DATA  = 2'h1,   // Data bus load, literals included
    FPC_DEBUG = 2'h2    // Debugger read
  } fpc_kind_t;

  // Controller states, Gray along the program path
  typedef enum logic [2:0] {
    FPC_IDLE   = 3'h0,
    FPC_RDREQ  = 3'h1,
    FPC_RDCAP  = 3'h3,
    FPC_RUN    = 3'h2,
    FPC_FINISH = 3'h6
  } fpc_state_t;

  // One read access request
  typedef struct packed {
    logic        valid;
    fpc_kind_t   kind;
    logic [31:0] addr;
  } fpc_acc_t;

  // Nonvolatile write strobe toward the flash-resident store
  typedef struct packed {
    logic        en;    // One-cycle pulse
    logic [1:0]  sel;   // 0 read enable, 1 program enable, 2 debug word
    logic [31:0] data;
  } fpc_nvwr_t;

endpackage : fpc_pkg
`default_nettype wire

// >>> logic/fpc_ctrl.sv
// Flash protection controller: APB registers, command sequencer, access checker.
// Assumes all inputs are on SYS_CLK; nonvolatile copies arrive on NV_* ports
// and the array returns read data one cycle after FLASH_RD.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.svh"

module fpc_ctrl #(
  parameter int NREG     = 32,          // Number of 2 KB regions
  parameter int PGM_US   = `FPC_PGM_US,
  parameter int ERASE_US = `FPC_ERASE_US
) (
  input  wire logic              SYS_CLK,
  input  wire logic              ARST_N,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Read access check from instruction, data and debug buses
  input  wire fpc_pkg::fpc_acc_t ACC_REQ,
  output logic                   ACC_OK,
  output logic                   ACC_FAULT,
  output logic                   DBG_BLOCK,
  // Flash array side
  output logic                   FLASH_RD,
  output logic                   FLASH_PGM,
  output logic                   FLASH_ERASE,
  output logic [31:0]            FLASH_ADDR,
  output logic [31:0]            FLASH_WDATA,
  input  wire logic [31:0]       FLASH_RDATA,
  // Nonvolatile store
  input  wire logic [31:0]       NV_RE,
  input  wire logic [31:0]       NV_PE,
  input  wire logic [31:0]       NV_DBG,
  output fpc_pkg::fpc_nvwr_t     NV_WR,
  // Interrupt
  output logic                   FLASH_IRQ
);
  import fpc_pkg::*;

  localparam int RIW = $clog2(NREG);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [31:0]  addr_q;        // Target address
  logic [31:0]  data_q;        // Program data / debug commit data
  logic [3:0]   cmd_q;         // Pending operation bits
  logic [1:0]   raw_q;         // Raw status
  logic [1:0]   mask_q;        // Interrupt masks
  logic [NREG-1:0] re_q;       // Region read enables
  logic [NREG-1:0] pe_q;       // Region program enables
  logic [7:0]   usec_q;        // Cycles per microsecond minus one
  logic [31:0]  dbg_q;         // Working debug word
  logic         dbg_off_q;     // Debug port disabled
  logic         boot_q;        // Load nonvolatile copies once
  logic [31:0]  rdata_d;       // Read mux
  logic         err_d;         // Unmapped address
  logic         wr_en;         // Write taken this edge
  logic         cmd_wr;        // Keyed command write
  logic [1:0]   st_set;        // Status events this cycle
  logic [1:0]   st_clr;        // Status clears this cycle
  fpc_state_t   state_q;       // Sequencer state
  logic [7:0]   tick_cnt_q;    // Microsecond divider
  logic         tick;          // Microsecond strobe
  logic [15:0]  us_cnt_q;      // Microseconds elapsed
  logic [15:0]  us_lim;        // Duration of current operation
  logic [RIW-1:0] tgt_reg;     // Region of the target address
  logic [RIW-1:0] acc_reg;     // Region of the access address
  logic         refuse;        // Program/erase on protected region

  assign tgt_reg = addr_q[11 +: RIW];
  assign acc_reg = ACC_REQ.addr[11 +: RIW];

  // ---------------------------------------------------------------
  // APB handshake
  // ---------------------------------------------------------------
  // No wait state; read data and error are loaded in the setup cycle and come straight from flops
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE && !PREADY) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? 32'h0000_0000 : rdata_d;
      PSLVERR <= err_d;
    end else begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  assign wr_en  = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  // Only a keyed write with exactly one known bit starts anything
  assign cmd_wr = wr_en && (PADDR == `FPC_OFF_CMD) && (state_q == FPC_IDLE)
                  && (PWDATA[31:16] == `FPC_CMD_KEY)
                  && (PWDATA[3:0] == `FPC_CMD_WRITE || PWDATA[3:0] == `FPC_CMD_ERASE
                      || PWDATA[3:0] == `FPC_CMD_COMMIT);

  // Read mux and decode
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    unique case (PADDR)
      `FPC_OFF_ADDR: rdata_d = addr_q;
      `FPC_OFF_DATA: rdata_d = data_q;
      `FPC_OFF_CMD:  rdata_d = {28'h000_0000, cmd_q};
      `FPC_OFF_RIS:  rdata_d = {30'h0000_0000, raw_q};
      `FPC_OFF_IM:   rdata_d = {30'h0000_0000, mask_q};
      `FPC_OFF_MISC: rdata_d = {30'h0000_0000, raw_q & mask_q};
      `FPC_OFF_RE:   rdata_d = 32'(re_q);
      `FPC_OFF_PE:   rdata_d = 32'(pe_q);
      `FPC_OFF_USEC: rdata_d = {24'h00_0000, usec_q};
      `FPC_OFF_DBG:  rdata_d = dbg_q;
      default:       err_d   = 1'b1;   // Unmapped answers with an error
    endcase
  end

  // ---------------------------------------------------------------
  // Plain configuration registers
  // ---------------------------------------------------------------
  // Address, data, mask and reload
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_q <= 32'h0000_0000;
      data_q <= 32'h0000_0000;
      mask_q <= 2'h0;
      usec_q <= `FPC_USEC_RST;
    end else if (wr_en) begin
      if (PADDR == `FPC_OFF_ADDR) addr_q <= PWDATA;
      if (PADDR == `FPC_OFF_DATA) data_q <= PWDATA;
      if (PADDR == `FPC_OFF_IM)   mask_q <= PWDATA[1:0];
      if (PADDR == `FPC_OFF_USEC) usec_q <= PWDATA[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Protection and debug words
  // ---------------------------------------------------------------
  // Reset gives factory ones except debug word bit 0; the first edge loads committed copies,
  // so a power-on drops uncommitted clears
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      boot_q <= 1'b1;
      re_q   <= NREG'(`FPC_PROT_RST);
      pe_q   <= NREG'(`FPC_PROT_RST);
      dbg_q  <= `FPC_DBG_RST;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      re_q   <= NV_RE[NREG-1:0];
      pe_q   <= NV_PE[NREG-1:0];
      dbg_q  <= NV_DBG;
    end else if (wr_en) begin
      // Writes may only clear bits
      if (PADDR == `FPC_OFF_RE)  re_q  <= re_q & PWDATA[NREG-1:0];
      if (PADDR == `FPC_OFF_PE)  pe_q  <= pe_q & PWDATA[NREG-1:0];
      if (PADDR == `FPC_OFF_DBG) dbg_q <= dbg_q & PWDATA;
    end
  end

  // Debug lock is decided only from the committed word at power-up;
  // only a reset clears it, and the next boot load decides it again
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dbg_off_q <= 1'b0;
      DBG_BLOCK <= 1'b0;
    end else begin
      if (boot_q && NV_DBG[1:0] == 2'b00) dbg_off_q <= 1'b1;
      DBG_BLOCK <= dbg_off_q;
    end
  end

  // ---------------------------------------------------------------
  // Read access checker
  // ---------------------------------------------------------------
  // Fetches always pass; data and debug reads need read enable
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ACC_OK    <= 1'b0;
      ACC_FAULT <= 1'b0;
    end else begin
      ACC_OK    <= 1'b0;
      ACC_FAULT <= 1'b0;
      if (ACC_REQ.valid) begin
        if (ACC_REQ.kind == FPC_DEBUG && dbg_off_q) begin
          ACC_FAULT <= 1'b1;
        end else if (ACC_REQ.kind == FPC_FETCH) begin
          ACC_OK    <= 1'b1;
        end else if (!re_q[acc_reg]) begin
          ACC_FAULT <= 1'b1;
        end else begin
          ACC_OK    <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Microsecond time base
  // ---------------------------------------------------------------
  // Reload sets cycles per tick; wrong reload only skews timing
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_q <= 8'h00;
    end else if (state_q != FPC_RUN || tick) begin
      tick_cnt_q <= usec_q;
    end else begin
      tick_cnt_q <= tick_cnt_q - 8'h01;
    end
  end

  assign tick   = (state_q == FPC_RUN) && (tick_cnt_q == 8'h00);
  assign us_lim = 16'(FLASH_ERASE ? ERASE_US : PGM_US);
  assign refuse = !pe_q[tgt_reg] && (PWDATA[3:0] != `FPC_CMD_COMMIT);

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  // Pending bits stay visible until the operation ends
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q     <= FPC_IDLE;
      cmd_q       <= 4'h0;
      us_cnt_q    <= 16'h0000;
      FLASH_RD    <= 1'b0;
      FLASH_PGM   <= 1'b0;
      FLASH_ERASE <= 1'b0;
      FLASH_ADDR  <= 32'h0000_0000;
      FLASH_WDATA <= 32'h0000_0000;
      NV_WR       <= '0;
    end else begin
      NV_WR.en <= 1'b0;
      FLASH_RD <= 1'b0;
      unique case (state_q)
        FPC_IDLE: begin
          us_cnt_q <= 16'h0000;
          if (cmd_wr && refuse) begin
            state_q <= FPC_IDLE;
          end else if (cmd_wr) begin
            cmd_q <= PWDATA[3:0];
            if (PWDATA[3:0] == `FPC_CMD_WRITE) begin
              FLASH_ADDR <= {addr_q[31:2], 2'b00};
              FLASH_RD   <= 1'b1;
              state_q    <= FPC_RDREQ;
            end else if (PWDATA[3:0] == `FPC_CMD_ERASE) begin
              FLASH_ADDR  <= {addr_q[31:10], 10'h000};
              FLASH_ERASE <= 1'b1;
              state_q     <= FPC_RUN;
            end else begin
              // Commit: unknown targets finish with no store
              state_q <= FPC_FINISH;
              if (addr_q == `FPC_CMT_RE) begin
                NV_WR <= '{en: 1'b1, sel: 2'h0, data: 32'(re_q)};
              end else if (addr_q == `FPC_CMT_PE) begin
                NV_WR <= '{en: 1'b1, sel: 2'h1, data: 32'(pe_q)};
              end else if (addr_q == `FPC_CMT_DBG) begin
                NV_WR <= '{en: 1'b1, sel: 2'h2, data: data_q & dbg_q};
              end
            end
          end
        end
        FPC_RDREQ: begin
          state_q <= FPC_RDCAP;   // Array answers one cycle later
        end
        FPC_RDCAP: begin
          // Merge keeps zeros zero: a word can only lose ones
          FLASH_WDATA <= FLASH_RDATA & data_q;
          FLASH_PGM   <= 1'b1;
          state_q     <= FPC_RUN;
        end
        FPC_RUN: begin
          if (tick) begin
            us_cnt_q <= us_cnt_q + 16'h0001;
            if (us_cnt_q + 16'h0001 >= us_lim) begin
              FLASH_PGM   <= 1'b0;
              FLASH_ERASE <= 1'b0;
              state_q     <= FPC_FINISH;
            end
          end
        end
        FPC_FINISH: begin
          cmd_q   <= 4'h0;
          state_q <= FPC_IDLE;
        end
        default: state_q <= FPC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------
  assign st_set[`FPC_ST_PROG] = (state_q == FPC_FINISH) && (cmd_q != `FPC_CMD_COMMIT);
  assign st_set[`FPC_ST_ACC]  = cmd_wr && refuse;
  assign st_clr = (wr_en && PADDR == `FPC_OFF_MISC) ? PWDATA[1:0] : 2'h0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      raw_q     <= 2'h0;
      FLASH_IRQ <= 1'b0;
    end else begin
      raw_q     <= (raw_q & ~st_clr) | st_set;
      FLASH_IRQ <= |(raw_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  a_xo_data_fault: assert property (
    ACC_REQ.valid && ACC_REQ.kind == FPC_DATA && !re_q[acc_reg] |=> ACC_FAULT && !ACC_OK)
    else $error("data read of read-protected region not faulted");
  a_fetch_allowed: assert property (
    ACC_REQ.valid && ACC_REQ.kind == FPC_FETCH |=> ACC_OK && !ACC_FAULT)
    else $error("instruction fetch refused");
  a_open_read_ok: assert property (
    ACC_REQ.valid && ACC_REQ.kind == FPC_DATA && re_q[acc_reg] |=> ACC_OK)
    else $error("read of open region refused");
  a_debug_blocked: assert property (
    ACC_REQ.valid && ACC_REQ.kind == FPC_DEBUG && dbg_off_q |=> ACC_FAULT ##1 DBG_BLOCK)
    else $error("debug access passed while disabled");
  a_debug_sticky: assert property (dbg_off_q |=> dbg_off_q [*8])
    else $error("debug lock released");
  a_clear_only: assert property (!boot_q |=> (re_q & ~$past(re_q)) == '0)
    else $error("protection bit went from zero to one");
  a_refuse_prog: assert property (
    cmd_wr && refuse |=> state_q == FPC_IDLE && !FLASH_PGM && !FLASH_ERASE && raw_q[1])
    else $error("protected region change not refused");
  a_done_flag: assert property (
    state_q == FPC_RUN ##1 state_q == FPC_FINISH && cmd_q != `FPC_CMD_COMMIT
    |=> raw_q[0] && cmd_q == 4'h0)
    else $error("completion flag not set");
  a_irq_masked: assert property (
    ##1 FLASH_IRQ == $past(|(raw_q & mask_q)))
    else $error("interrupt does not follow masked status");
  a_w1c_clear: assert property (
    wr_en && PADDR == `FPC_OFF_MISC && PWDATA[0] && !st_set[0] |=> !raw_q[0])
    else $error("write one did not clear status");
  a_key_needed: assert property (
    wr_en && PADDR == `FPC_OFF_CMD && PWDATA[31:16] != `FPC_CMD_KEY
    && state_q == FPC_IDLE |=> state_q == FPC_IDLE)
    else $error("unkeyed command started an operation");

  c_program: cover property (state_q == FPC_RDCAP ##1 FLASH_PGM);
  c_erase:   cover property (FLASH_ERASE ##[1:1000] state_q == FPC_FINISH);
  c_refused: cover property (cmd_wr && refuse);
  c_fault:   cover property (ACC_FAULT);

endmodule : fpc_ctrl
`default_nettype wire

// >>> verification/fpc_flash_model.sv
// Behavioural model of the flash array behind the protection controller.
// Assumes the controller drives FLASH_* on SYS_CLK and reads back one cycle later.
`timescale 1ns/1ps
`default_nettype none

module fpc_flash_model (
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic        pgm,
  input  wire logic        erase,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output logic [31:0]      rdata
);
  // ---------------------------------------------------------------
  // Storage: 64 KB of words, blank means all ones
  // ---------------------------------------------------------------
  logic [31:0] mem [16384];  // Word array indexed by addr[15:2]

  initial begin
    foreach (mem[i]) mem[i] = 32'hFFFF_FFFF;
    rdata = 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // Array behaviour
  // ---------------------------------------------------------------
  // Read answers one cycle later; idle data toggles so stale values never pass
  always @(posedge clk) begin
    if (rd) begin
      rdata <= mem[addr[15:2]];
    end else begin
      rdata <= ~rdata;
    end
    // Stores the word as driven, so a missing one-to-zero merge shows up
    if (pgm) begin
      mem[addr[15:2]] <= wdata;
    end
    // Whole 1 KB block back to ones
    if (erase) begin
      for (int i = 0; i < 256; i++) mem[{addr[15:10], i[7:0]}] <= 32'hFFFF_FFFF;
    end
  end
endmodule : fpc_flash_model

`default_nettype wire

// >>> verification/tb_flash_protection_control.sv
// Self-checking bench for the flash protection controller over APB.
// Assumes fpc_defines.svh on the include path and the flash model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_defines.svh"

module tb_flash_protection_control;
  import fpc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        acc_ok, acc_fault, dbg_block, f_rd, f_pgm, f_erase, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, e, a, f_addr, f_wdata, f_rdata;
  logic [31:0] nv_re, nv_pe, nv_dbg;  // Nonvolatile store copies
  fpc_acc_t    acc;
  fpc_nvwr_t   nvwr;
  int          mismatches, samples_checked, cyc, pgm_len;

  fpc_ctrl #(.NREG(32), .PGM_US(1), .ERASE_US(1)) i_dut (
    .SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ACC_REQ(acc), .ACC_OK(acc_ok), .ACC_FAULT(acc_fault), .DBG_BLOCK(dbg_block),
    .FLASH_RD(f_rd), .FLASH_PGM(f_pgm), .FLASH_ERASE(f_erase), .FLASH_ADDR(f_addr),
    .FLASH_WDATA(f_wdata), .FLASH_RDATA(f_rdata), .NV_RE(nv_re), .NV_PE(nv_pe),
    .NV_DBG(nv_dbg), .NV_WR(nvwr), .FLASH_IRQ(irq));

  fpc_flash_model i_flash (.clk(clk), .rd(f_rd), .pgm(f_pgm), .erase(f_erase),
    .addr(f_addr), .wdata(f_wdata), .rdata(f_rdata));

  // ---------------------------------------------------------------
  // Clock, timeout, program length, nonvolatile store
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (f_pgm === 1'b1) pgm_len++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // Store only clears bits, like the real cells
  always @(posedge clk) begin
    if (nvwr.en === 1'b1) begin
      if (nvwr.sel == 2'h0) nv_re <= nv_re & nvwr.data;
      if (nvwr.sel == 2'h1) nv_pe <= nv_pe & nvwr.data;
      if (nvwr.sel == 2'h2) nv_dbg <= nv_dbg & nvwr.data;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // One APB transfer; waits for the slave, result in rd and err
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Keyed command with address and data, then poll until it clears
  task cmd(input logic [31:0] ad, input logic [31:0] wd, input logic [3:0] op);
    apb(1'b1, `FPC_OFF_DATA, wd);
    apb(1'b1, `FPC_OFF_ADDR, ad);
    apb(1'b1, `FPC_OFF_CMD, {`FPC_CMD_KEY, 12'h000, op});
    do apb(1'b0, `FPC_OFF_CMD, 32'h0); while (rd[3:0] !== 4'h0);
  endtask : cmd

  // One read request; answer is sampled the cycle after it is taken
  task acc_chk(input fpc_kind_t k, input logic [31:0] ad, input logic flt);
    @(posedge clk);
    acc <= '{1'b1, k, ad};
    @(posedge clk);
    acc.valid <= 1'b0;
    @(posedge clk);
    chk("acc_ok", acc_ok, !flt);
    chk("acc_fault", acc_fault, flt);
  endtask : acc_chk

  task rst();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rst

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    acc = '0;
    {nv_re, nv_pe, nv_dbg} = {32'hFFFF_FFFF, 32'hFFFF_FFFF, `FPC_DBG_RST};
    void'($urandom(58583));
    rst();
    apb(1'b0, `FPC_OFF_USEC, 32'h0);
    chk("usec_rst", rd, 32'h18);
    apb(1'b0, `FPC_OFF_RE, 32'h0);
    chk("re_rst", rd, 32'hFFFF_FFFF);
    apb(1'b0, `FPC_OFF_PE, 32'h0);
    chk("pe_rst", rd, 32'hFFFF_FFFF);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", err, 1);
    // Program twice into region 2: bits only clear, reload sets length
    apb(1'b1, `FPC_OFF_USEC, 32'h3);
    a = 32'h1000 + ($urandom_range(0, 255) << 2);
    d = $urandom;
    e = $urandom;
    pgm_len = 0;
    cmd(a, d, `FPC_CMD_WRITE);
    chk("pgm_len", (pgm_len >= 4 && pgm_len <= 6), 1);
    cmd(a, e, `FPC_CMD_WRITE);
    chk("word", i_flash.mem[a[15:2]], d & e);
    apb(1'b0, `FPC_OFF_RIS, 32'h0);
    chk("raw_done", rd, 32'h1);
    chk("irq_off", irq, 0);
    // Mask, masked view, write-1-clear
    apb(1'b1, `FPC_OFF_IM, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq_on", irq, 1);
    apb(1'b1, `FPC_OFF_MISC, 32'h0);
    apb(1'b0, `FPC_OFF_MISC, 32'h0);
    chk("masked", rd, 32'h1);
    apb(1'b1, `FPC_OFF_MISC, 32'h1);
    apb(1'b0, `FPC_OFF_RIS, 32'h0);
    chk("raw_clr", rd, 32'h0);
    // Erase the block back to ones
    cmd(a, 32'h0, `FPC_CMD_ERASE);
    chk("erased", i_flash.mem[a[15:2]], 32'hFFFF_FFFF);
    apb(1'b1, `FPC_OFF_MISC, 32'h3);
    // Protect region 2; clear-only register; refused program flags access
    apb(1'b1, `FPC_OFF_PE, ~32'h4);
    apb(1'b1, `FPC_OFF_PE, 32'hFFFF_FFFF);
    apb(1'b0, `FPC_OFF_PE, 32'h0);
    chk("pe_clear_only", rd, ~32'h4);
    cmd(a, 32'h0, `FPC_CMD_WRITE);
    chk("refused", i_flash.mem[a[15:2]], 32'hFFFF_FFFF);
    apb(1'b0, `FPC_OFF_RIS, 32'h0);
    chk("raw_acc", rd, 32'h2);
    chk("irq_acc", irq, 1);
    // Address still in protected region 2, and a wrong key starts nothing
    apb(1'b1, `FPC_OFF_CMD, 32'hA441_0001);
    apb(1'b0, `FPC_OFF_CMD, 32'h0);
    chk("bad_key", rd, 32'h0);
    // Read-protect region 5; fetch passes, data and debug fault
    apb(1'b1, `FPC_OFF_RE, ~32'h20);
    for (int i = 0; i < 6; i++) begin
      acc_chk(fpc_kind_t'(i % 3), (i < 3) ? 32'h2800 : 32'h2000, i == 1 || i == 2);
    end
    // Commit program enable; uncommitted read enable restored by reset
    cmd(32'h1, 32'h0, `FPC_CMD_COMMIT);
    chk("nv_pe", nv_pe, ~32'h4);
    rst();
    apb(1'b0, `FPC_OFF_PE, 32'h0);
    chk("pe_kept", rd, ~32'h4);
    apb(1'b0, `FPC_OFF_RE, 32'h0);
    chk("re_back", rd, 32'hFFFF_FFFF);
    // Lock the debug port, then try to undo it
    cmd(`FPC_CMT_DBG, 32'hFFFF_FFFC, `FPC_CMD_COMMIT);
    rst();
    // Lock output lands on the second edge after release; look one edge later
    @(posedge clk);
    chk("dbg_lock", dbg_block, 1);
    acc_chk(FPC_DEBUG, 32'h0, 1'b1);
    acc_chk(FPC_FETCH, 32'h0, 1'b0);
    cmd(`FPC_CMT_DBG, 32'hFFFF_FFFF, `FPC_CMD_COMMIT);
    rst();
    @(posedge clk);
    chk("dbg_stays", dbg_block, 1);
    end_sim();
  end
endmodule : tb_flash_protection_control

`default_nettype wire
